// ### design/ufc_core.sv
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
// Operation
// - hysteresis bits apply only when trigger table D is selected.
// - hysteresis codes map to fixed character counts, one map for all tables.
// - hysteresis bits reset to zero, using next trigger level.
// - infrared receive input inverted when polarity bit is one.
// - half duplex drops RTS after last stop bit leaves shifter.
// - half duplex raises RTS when a byte is loaded for transmit.
// - transmit interrupt from holding empty, or shifter empty in half duplex.
// - tables A-C use next trigger level above and below.
// - transmit flow bits choose none, second, first or both pairs.
// - receive flow bits choose none, second, first, either or sequence.
// - dual modes send or match two consecutive characters.
// - stop characters sent about two character times after trigger.
// - resume sent below lower level or trigger minus hysteresis.
// - enhanced enable gates writes to protected enhanced bits.
// - reset clears protected bits and the enhanced enable.
// - special detect matches second stop char, stores, sets status bit.
// - with compare code 01 matched char is dropped, two interrupts.
// - auto RTS/DTR interrupts at trigger, drives high at upper level.
// - auto RTS/DTR drives low again below the lower level.
// - modem control bit 2 picks RTS or DTR; otherwise plain output.
// - half duplex turnaround delayed 0 to 15 bit times.
// - auto CTS/DSR stops transmitter while selected input is high.
module ufc_core (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // uart core status, same clock
  input wire logic [6:0] rx_level,
  input wire ufc_pkg::ufc_char_t rx_char,
  input wire logic tx_load,
  input wire logic thr_empty,
  input wire logic tsr_empty,
  input wire logic bit_tick,
  input wire logic char_tick,
  // flow character request to transmitter
  output ufc_pkg::ufc_char_t flow_char,
  input wire logic flow_char_ready,
  // uart core controls
  output logic rx_store,
  output logic tx_halt,
  output logic tx_int,
  output logic rx_trig_int,
  output logic special_int,
  output logic stop_int,
  output logic ir_rx_data,
  // pins
  input wire logic ir_rx_pin,
  input wire logic cts_n_pin,
  input wire logic dsr_n_pin,
  output logic rts_n,
  output logic dtr_n
);
  logic [7:0] feature_control, enhanced_feature_control, modem_control;
  logic [7:0] interrupt_enable_register, interrupt_status_register;
  logic [7:0] fifo_control_register, modem_status_register;
  logic [7:0] resume_char_first, resume_char_second, stop_char_first, stop_char_second;
  logic [7:0] rx_trig, next_up, next_lo;
  logic [7:0] aw_addr, w_data;
  logic aw_held, w_held, wr_go, enh;
  logic [2:0] pin_s1, pin_s2;
  logic [7:0] hyst, level, upper, lower;
  logic table_d, hw_stop, sw_stopped, stop_due, stop_sent, seq_stop, seq_resume;
  logic [1:0] char_cnt;
  logic [1:0] tx_sel, rx_sel;
  logic seq_mode, cmp_first, cmp_second, stop_hit, resume_hit, special_hit, drop;
  logic hd_high, hd_wait;
  logic [3:0] hd_cnt;
  logic [31:0] next_rdata;
  logic next_rerr;

  typedef enum logic [1:0] {
    UFC_IDLE = 2'b00,
    UFC_SEND1 = 2'b01,
    UFC_SEND2 = 2'b10
  } ufc_state_t;
  ufc_state_t state;
  logic send_stop;

  assign enh = enhanced_feature_control[ufc_pkg::EF_ENH_EN];
  assign level = {1'b0, rx_level};
  assign tx_sel = enhanced_feature_control[3:2];
  assign rx_sel = enhanced_feature_control[1:0];

  // write channel acceptance, address and data in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp = s_axi_rvalid && next_rerr ? ufc_pkg::AXI_SLVERR : ufc_pkg::AXI_OKAY;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= ufc_pkg::RST_ZERO;
      w_data <= ufc_pkg::RST_ZERO;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ufc_pkg::AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr > ufc_pkg::ADDR_NEXT_LO || aw_addr[1:0] != 2'h0) ?
                       ufc_pkg::AXI_SLVERR : ufc_pkg::AXI_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register writes; enhanced bits guarded by the enable
  function automatic logic [7:0] guard(input logic [7:0] old, input logic [7:0] nv,
                                       input logic [7:0] prot, input logic en);
    return en ? nv : ((nv & ~prot) | (old & prot));
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      feature_control <= ufc_pkg::RST_ZERO;
      enhanced_feature_control <= ufc_pkg::RST_ZERO;
      modem_control <= ufc_pkg::RST_ZERO;
      interrupt_enable_register <= ufc_pkg::RST_ZERO;
      fifo_control_register <= ufc_pkg::RST_ZERO;
      modem_status_register <= ufc_pkg::RST_ZERO;
      resume_char_first <= ufc_pkg::RST_ZERO;
      resume_char_second <= ufc_pkg::RST_ZERO;
      stop_char_first <= ufc_pkg::RST_ZERO;
      stop_char_second <= ufc_pkg::RST_ZERO;
      rx_trig <= ufc_pkg::RST_RX_TRIG;
      next_up <= ufc_pkg::RST_NEXT_UP;
      next_lo <= ufc_pkg::RST_NEXT_LO;
    end else if (wr_go) begin
      unique case (aw_addr)
        ufc_pkg::ADDR_FEATURE: feature_control <= w_data;
        ufc_pkg::ADDR_ENHANCED: enhanced_feature_control <= w_data;
        ufc_pkg::ADDR_MODEM_CTL:
          modem_control <= guard(modem_control, w_data, ufc_pkg::PROT_MCR, enh);
        ufc_pkg::ADDR_INT_ENABLE: interrupt_enable_register <=
          guard(interrupt_enable_register, w_data, ufc_pkg::PROT_IER, enh);
        ufc_pkg::ADDR_FIFO_CTL: fifo_control_register <=
          guard(fifo_control_register, w_data, ufc_pkg::PROT_FCR, enh);
        ufc_pkg::ADDR_MODEM_STAT: modem_status_register <=
          guard(modem_status_register, w_data, ufc_pkg::PROT_MSR, enh);
        ufc_pkg::ADDR_RESUME_1: resume_char_first <= w_data;
        ufc_pkg::ADDR_RESUME_2: resume_char_second <= w_data;
        ufc_pkg::ADDR_STOP_1: stop_char_first <= w_data;
        ufc_pkg::ADDR_STOP_2: stop_char_second <= w_data;
        ufc_pkg::ADDR_RX_TRIG: rx_trig <= w_data;
        ufc_pkg::ADDR_NEXT_UP: next_up <= w_data;
        ufc_pkg::ADDR_NEXT_LO: next_lo <= w_data;
        default: ;
      endcase
    end
  end

  // read data mux
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (s_axi_araddr)
      ufc_pkg::ADDR_FEATURE: next_rdata[7:0] = feature_control;
      ufc_pkg::ADDR_ENHANCED: next_rdata[7:0] = enhanced_feature_control;
      ufc_pkg::ADDR_MODEM_CTL: next_rdata[7:0] = modem_control;
      ufc_pkg::ADDR_INT_ENABLE: next_rdata[7:0] = interrupt_enable_register;
      ufc_pkg::ADDR_INT_STATUS: next_rdata[7:0] = interrupt_status_register;
      ufc_pkg::ADDR_FIFO_CTL: next_rdata[7:0] = fifo_control_register;
      ufc_pkg::ADDR_MODEM_STAT:
        next_rdata[7:0] = {modem_status_register[7:4], 2'h0, ~pin_s2[2], ~pin_s2[1]};
      ufc_pkg::ADDR_RESUME_1: next_rdata[7:0] = resume_char_first;
      ufc_pkg::ADDR_RESUME_2: next_rdata[7:0] = resume_char_second;
      ufc_pkg::ADDR_STOP_1: next_rdata[7:0] = stop_char_first;
      ufc_pkg::ADDR_STOP_2: next_rdata[7:0] = stop_char_second;
      ufc_pkg::ADDR_RX_TRIG: next_rdata[7:0] = rx_trig;
      ufc_pkg::ADDR_NEXT_UP: next_rdata[7:0] = next_up;
      ufc_pkg::ADDR_NEXT_LO: next_rdata[7:0] = next_lo;
      ufc_pkg::ADDR_FLOW_STAT:
        next_rdata[7:0] = {2'h0, hd_high, stop_sent, tx_halt, sw_stopped, hw_stop, state != UFC_IDLE};
      default: ;
    endcase
  end

  // read response, one cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      next_rerr <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      next_rerr <= s_axi_araddr > ufc_pkg::ADDR_FLOW_STAT || s_axi_araddr[1:0] != 2'h0;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // pin synchronisers: ir, cts, dsr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= 3'h7;
      pin_s2 <= 3'h7;
    end else begin
      pin_s1 <= {dsr_n_pin, cts_n_pin, ir_rx_pin};
      pin_s2 <= pin_s1;
    end
  end

  assign ir_rx_data = pin_s2[0] ^ feature_control[ufc_pkg::FC_IR_INV];

  // flow thresholds
  assign table_d = feature_control[7:6] == ufc_pkg::TABLE_D;
  assign hyst = ufc_pkg::ufc_hyst(feature_control[3:0]);
  // hysteresis only under table D; zero keeps next level; tables A-C
  assign upper = (table_d && hyst != 8'h00) ? rx_trig + hyst : next_up;
  assign lower = (table_d && hyst != 8'h00) ? rx_trig - hyst : next_lo;

  // hardware flow state with hysteresis
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hw_stop <= 1'b0;
      rx_trig_int <= 1'b0;
    end else begin
      rx_trig_int <= enhanced_feature_control[ufc_pkg::EF_AUTO_RTS] && level >= rx_trig;
      if (!enhanced_feature_control[ufc_pkg::EF_AUTO_RTS]) begin
        hw_stop <= 1'b0;
      end else if (level >= upper) begin
        hw_stop <= 1'b1;
      end else if (level < lower) begin
        hw_stop <= 1'b0;
      end
    end
  end

  // half duplex direction with turnaround delay
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hd_high <= 1'b0;
      hd_wait <= 1'b0;
      hd_cnt <= 4'h0;
    end else if (tx_load) begin
      hd_high <= 1'b1;
      hd_wait <= 1'b0;
    end else if (hd_high && tsr_empty && !hd_wait) begin
      hd_wait <= 1'b1;
      hd_cnt <= modem_status_register[7:4];
    end else if (hd_wait && hd_cnt == 4'h0) begin
      hd_high <= 1'b0;
      hd_wait <= 1'b0;
    end else if (hd_wait && bit_tick) begin
      hd_cnt <= hd_cnt - 4'h1;
    end
  end

  // modem outputs
  always_comb begin
    rts_n = ~modem_control[ufc_pkg::MC_RTS];
    dtr_n = ~modem_control[ufc_pkg::MC_DTR];
    // selected pin under auto control, else plain output
    if (modem_control[ufc_pkg::MC_SEL_DTR]) begin
      dtr_n = dtr_n | hw_stop;
    end else begin
      rts_n = rts_n | hw_stop;
    end
    if (feature_control[ufc_pkg::FC_HALF_DUPLEX]) begin
      rts_n = hd_high;
    end
  end

  assign tx_int = interrupt_enable_register[1] &&
                  (feature_control[ufc_pkg::FC_HALF_DUPLEX] ? tsr_empty : thr_empty);

  assign tx_halt = sw_stopped || (enhanced_feature_control[ufc_pkg::EF_AUTO_CTS] &&
                   (modem_control[ufc_pkg::MC_SEL_DTR] ? pin_s2[2] : pin_s2[1]));

  assign seq_mode = rx_sel == 2'h3 && (tx_sel == 2'h0 || tx_sel == 2'h3);
  assign cmp_first = rx_sel == 2'h2 || (rx_sel == 2'h3 && !seq_mode);
  assign cmp_second = rx_sel == 2'h1 || (rx_sel == 2'h3 && !seq_mode);
  assign stop_hit = rx_char.valid && ((cmp_first && rx_char.data == stop_char_first) ||
                    (cmp_second && rx_char.data == stop_char_second) ||
                    (seq_mode && seq_stop && rx_char.data == stop_char_second));
  assign resume_hit = rx_char.valid && ((cmp_first && rx_char.data == resume_char_first) ||
                      (cmp_second && rx_char.data == resume_char_second) ||
                      (seq_mode && seq_resume && rx_char.data == resume_char_second));
  assign special_hit = rx_char.valid && enhanced_feature_control[ufc_pkg::EF_SPECIAL] &&
                       rx_char.data == stop_char_second;
  // code 01 drops matched char; flow chars not stored
  assign drop = stop_hit || resume_hit;
  assign rx_store = rx_char.valid && !drop;
  assign special_int = interrupt_status_register[ufc_pkg::IS_SPECIAL];
  assign stop_int = interrupt_status_register[ufc_pkg::IS_STOP];

  // receive flow state and status flags; set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_stopped <= 1'b0;
      seq_stop <= 1'b0;
      seq_resume <= 1'b0;
      interrupt_status_register <= ufc_pkg::RST_ZERO;
    end else begin
      if (rx_char.valid) begin
        seq_stop <= rx_char.data == stop_char_first;
        seq_resume <= rx_char.data == resume_char_first;
      end
      if (rx_sel == 2'h0) begin
        sw_stopped <= 1'b0;
      end else if (stop_hit) begin
        sw_stopped <= 1'b1;
      end else if (resume_hit) begin
        sw_stopped <= 1'b0;
      end
      if (wr_go && aw_addr == ufc_pkg::ADDR_INT_STATUS && enh) begin
        interrupt_status_register <= w_data & ufc_pkg::PROT_ISR;
      end
      if (special_hit) begin
        interrupt_status_register[ufc_pkg::IS_SPECIAL] <= 1'b1;
      end
      if (stop_hit) begin
        interrupt_status_register[ufc_pkg::IS_STOP] <= 1'b1;
      end
    end
  end

  // stop timer: two character times after trigger
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      char_cnt <= 2'h0;
      stop_due <= 1'b0;
    end else if (tx_sel == 2'h0 || level < rx_trig || stop_sent) begin
      char_cnt <= 2'h0;
      stop_due <= 1'b0;
    end else if (char_tick && !stop_due) begin
      char_cnt <= char_cnt + 2'h1;
      stop_due <= char_cnt + 2'h1 >= ufc_pkg::STOP_CHAR_TIMES;
    end
  end

  // flow character sender
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= UFC_IDLE;
      stop_sent <= 1'b0;
      send_stop <= 1'b0;
      flow_char <= '0;
    end else begin
      unique case (state)
        UFC_IDLE: begin
          if (tx_sel == 2'h0) begin
            stop_sent <= 1'b0;
          end else if (stop_sent ? level < lower : stop_due) begin
            // resume below lower level; pair choice
            state <= UFC_SEND1;
            send_stop <= !stop_sent; // stale stop_due never sends a second stop
            flow_char.valid <= 1'b1;
            flow_char.data <= tx_sel == 2'h1 ?
              (stop_sent ? resume_char_second : stop_char_second) :
              (stop_sent ? resume_char_first : stop_char_first);
          end
        end
        UFC_SEND1: begin
          if (flow_char_ready) begin
            // second char of the pair follows
            if (tx_sel == 2'h3) begin
              state <= UFC_SEND2;
              flow_char.data <= send_stop ? stop_char_second : resume_char_second;
            end else begin
              state <= UFC_IDLE;
              flow_char.valid <= 1'b0;
              stop_sent <= send_stop;
            end
          end
        end
        UFC_SEND2: begin
          if (flow_char_ready) begin
            state <= UFC_IDLE;
            flow_char.valid <= 1'b0;
            stop_sent <= send_stop;
          end
        end
        default: state <= UFC_IDLE;
      endcase
    end
  end

  // checks
  AST_HYST_D: assert property (@(posedge aclk) disable iff (!aresetn)
    !table_d |-> upper == next_up && lower == next_lo) else $error("hysteresis outside D");
  AST_IR_POL: assert property (@(posedge aclk) disable iff (!aresetn)
    ir_rx_data == (pin_s2[0] != feature_control[4])) else $error("ir polarity wrong");
  AST_HD_RISE: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_load && feature_control[5] |=> rts_n) else $error("rts not raised on load");
  AST_TX_INT: assert property (@(posedge aclk) disable iff (!aresetn)
    interrupt_enable_register[1] && feature_control[5] |-> tx_int == tsr_empty)
    else $error("tx interrupt source wrong");
  AST_ENH_LOCK: assert property (@(posedge aclk) disable iff (!aresetn)
    !enh |=> (interrupt_enable_register[7:4] == $past(interrupt_enable_register[7:4])))
    else $error("protected bits changed");
  AST_SPECIAL: assert property (@(posedge aclk) disable iff (!aresetn)
    special_hit |=> interrupt_status_register[4]) else $error("special flag missed");
  AST_DROP01: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_char.valid && rx_sel == 2'h1 && rx_char.data == stop_char_second |-> !rx_store)
    else $error("stop char stored");
  AST_HW_HIGH: assert property (@(posedge aclk) disable iff (!aresetn)
    enhanced_feature_control[6] && level >= upper |=> hw_stop) else $error("no stop at upper");
  AST_HW_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
    hw_stop && level < lower && level < upper |=> !hw_stop) else $error("no release");
  AST_CTS: assert property (@(posedge aclk) disable iff (!aresetn)
    enhanced_feature_control[7] && !modem_control[2] && pin_s2[1] |-> tx_halt)
    else $error("cts high not halting");
  COV_PAIR: cover property (@(posedge aclk) state == UFC_SEND1 ##[1:20] state == UFC_SEND2);
  COV_HD: cover property (@(posedge aclk) hd_wait ##[1:200] !hd_high);
  COV_SW: cover property (@(posedge aclk) stop_hit ##[1:100] resume_hit);
endmodule

// ### design/ufc_pkg.sv
package ufc_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_FEATURE = 8'h00;
  localparam logic [7:0] ADDR_ENHANCED = 8'h04;
  localparam logic [7:0] ADDR_MODEM_CTL = 8'h08;
  localparam logic [7:0] ADDR_INT_ENABLE = 8'h0C;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h10;
  localparam logic [7:0] ADDR_FIFO_CTL = 8'h14;
  localparam logic [7:0] ADDR_MODEM_STAT = 8'h18;
  localparam logic [7:0] ADDR_RESUME_1 = 8'h1C;
  localparam logic [7:0] ADDR_RESUME_2 = 8'h20;
  localparam logic [7:0] ADDR_STOP_1 = 8'h24;
  localparam logic [7:0] ADDR_STOP_2 = 8'h28;
  localparam logic [7:0] ADDR_RX_TRIG = 8'h2C;
  localparam logic [7:0] ADDR_NEXT_UP = 8'h30;
  localparam logic [7:0] ADDR_NEXT_LO = 8'h34;
  localparam logic [7:0] ADDR_FLOW_STAT = 8'h38;
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_NEXT_UP = 8'h3C;
  localparam logic [7:0] RST_NEXT_LO = 8'h10;
  localparam logic [7:0] RST_RX_TRIG = 8'h38;
  // masks of the bits guarded by the enhanced enable
  localparam logic [7:0] PROT_IER = 8'hF0;
  localparam logic [7:0] PROT_ISR = 8'h30;
  localparam logic [7:0] PROT_FCR = 8'h30;
  localparam logic [7:0] PROT_MCR = 8'hE0;
  localparam logic [7:0] PROT_MSR = 8'hF0;
  // field positions
  localparam int FC_IR_INV = 4;
  localparam int FC_HALF_DUPLEX = 5;
  localparam int EF_ENH_EN = 4;
  localparam int EF_SPECIAL = 5;
  localparam int EF_AUTO_RTS = 6;
  localparam int EF_AUTO_CTS = 7;
  localparam int MC_DTR = 0;
  localparam int MC_RTS = 1;
  localparam int MC_SEL_DTR = 2;
  localparam int IS_SPECIAL = 4;
  localparam int IS_STOP = 5;
  // timing: stop characters leave about two character times after trigger
  localparam logic [1:0] STOP_CHAR_TIMES = 2'h2;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  localparam logic [1:0] TABLE_D = 2'h3;

  // received character event
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } ufc_char_t;

  // hysteresis code to character count
  function automatic logic [7:0] ufc_hyst(input logic [3:0] code);
    logic [7:0] h;
    h = 8'h00;
    case (code)
      4'h1: h = 8'h04;
      4'h2: h = 8'h06;
      4'h3: h = 8'h08;
      4'h4: h = 8'h08;
      4'h5: h = 8'h10;
      4'h6: h = 8'h18;
      4'h7: h = 8'h20;
      4'h8: h = 8'h28;
      4'h9: h = 8'h2C;
      4'hA: h = 8'h30;
      4'hB: h = 8'h34;
      4'hC: h = 8'h0C;
      4'hD: h = 8'h14;
      4'hE: h = 8'h1C;
      4'hF: h = 8'h24;
      default: h = 8'h00;
    endcase
    return h;
  endfunction
endpackage

// ### test/ufc_core_tb.sv
`timescale 1ns/1ps
module ufc_core_tb;
  logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_bready = 1'h1, s_axi_rready = 1'h1, tx_load = 1'h0;
  logic thr_empty = 1'h1, tsr_empty = 1'h1, bit_tick = 1'h0, char_tick = 1'h0;
  logic ir_rx_pin = 1'h1, cts_n_pin = 1'h0, dsr_n_pin = 1'h0, slow = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, tk = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [6:0] rx_level = 7'h00;
  ufc_pkg::ufc_char_t rx_char = 9'h000, flow_char;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic flow_char_ready, rx_store, tx_halt, tx_int, rx_trig_int, special_int, stop_int;
  logic ir_rx_data, rts_n, dtr_n;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] got;
  int err_total = 0, samples_checked = 0, cyc = 0;
  ufc_core ufc_core_i (.*);
  ufc_peer ufc_peer_i (.*);
  initial forever #2.5 aclk = ~aclk;
  // bit and character ticks, and the hang limit
  always @(posedge aclk) begin
    tk <= tk + 8'h01;
    bit_tick <= tk[1:0] == 2'h0;
    char_tick <= tk[3:0] == 4'h0;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    chk(s_axi_bresp, a > 8'h34 ? 32'h2 : 32'h0);
  endtask
  // read and compare response code (bits 9:8) and register byte
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    chk({22'h00_0000, s_axi_rresp, s_axi_rdata[7:0]}, e);
  endtask
  // one received character; store decision is seen in its own cycle
  task automatic rx(input logic [7:0] d, input logic [31:0] st);
    rx_char <= {1'h1, d};
    #1 chk(rx_store, st);
    @(posedge aclk);
    rx_char <= 9'h000;
  endtask
  // wait for the far side to log the expected characters
  task automatic wg(input logic [15:0] e, input logic [15:0] m);
    repeat (300) if ((got & m) !== e) @(posedge aclk);
    chk(got & m, e);
  endtask
  task automatic ld();
    tx_load <= 1'h1;
    tsr_empty <= 1'h0;
    @(posedge aclk);
    tx_load <= 1'h0;
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk({rts_n, dtr_n}, 32'h3);
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h0);
    rdc(8'h0C, 32'h0);
    rdc(8'h3C, 32'h200);
    wr(8'h3C, 8'h00);
    wr(8'h0C, 8'hFF);
    rdc(8'h0C, 32'h0F);
    wr(8'h04, 8'h10);
    wr(8'h0C, 8'hFF);
    wr(8'h04, 8'h00);
    wr(8'h0C, 8'h02);
    rdc(8'h0C, 32'hF2);
    $display("test registers done");
    chk(ir_rx_data, 32'h1);
    wr(8'h00, 8'h10);
    ir_rx_pin <= 1'h0;
    repeat (4) @(posedge aclk);
    chk(ir_rx_data, 32'h1);
    wr(8'h04, 8'h10);
    wr(8'h18, 8'h20);
    wr(8'h00, 8'h20);
    ld();
    repeat (3) @(posedge aclk);
    chk(tx_int, 32'h0);
    tsr_empty <= 1'h1;
    repeat (4) @(posedge aclk);
    chk(rts_n, 32'h1);
    repeat (12) @(posedge aclk);
    chk({rts_n, tx_int}, 32'h1);
    ld();
    repeat (2) @(posedge aclk);
    chk(rts_n, 32'h1);
    tsr_empty <= 1'h1;
    wr(8'h00, 8'h00);
    chk(tx_int, 32'h1);
    $display("test pins done");
    wr(8'h08, 8'h02);
    chk(rts_n, 32'h0);
    wr(8'h04, 8'h40);
    rx_level <= 7'h3C;
    repeat (4) @(posedge aclk);
    chk({rts_n, rx_trig_int}, 32'h3);
    rx_level <= 7'h0F;
    repeat (4) @(posedge aclk);
    chk(rts_n, 32'h0);
    wr(8'h04, 8'h80);
    cts_n_pin <= 1'h1;
    repeat (4) @(posedge aclk);
    chk(tx_halt, 32'h1);
    cts_n_pin <= 1'h0;
    repeat (4) @(posedge aclk);
    chk(tx_halt, 32'h0);
    $display("test hardware flow done");
    wr(8'h1C, 8'h91);
    wr(8'h20, 8'h92);
    wr(8'h24, 8'h93);
    wr(8'h28, 8'h94);
    slow <= 1'h1;
    for (int i = 1; i < 4; i++) begin
      wr(8'h04, 8'h00);
      wr(8'h04, {4'h0, i[1:0], 2'h3});
      rx_level <= 7'h38;
      wg(i == 3 ? 16'h9394 : {8'h00, i == 1 ? 8'h94 : 8'h93}, i == 3 ? 16'hFFFF : 16'h00FF);
      rx_level <= 7'h0F;
      wg(i == 3 ? 16'h9192 : {8'h00, i == 1 ? 8'h92 : 8'h91}, i == 3 ? 16'hFFFF : 16'h00FF);
    end
    wr(8'h04, 8'h00);
    wr(8'h00, 8'hC5);
    wr(8'h04, 8'h0A);
    rx_level <= 7'h38;
    wg(16'h0093, 16'h00FF);
    rx_level <= 7'h28;
    repeat (60) @(posedge aclk);
    chk(got[7:0], 32'h93);
    rx_level <= 7'h27;
    wg(16'h0091, 16'h00FF);
    $display("test software flow done");
    wr(8'h04, 8'h00);
    wr(8'h04, 8'h30);
    rx(8'h41, 32'h1);
    rx(8'h94, 32'h1);
    rdc(8'h10, 32'h10);
    wr(8'h04, 8'h00);
    wr(8'h04, 8'h31);
    wr(8'h10, 8'h00);
    rx(8'h94, 32'h0);
    @(posedge aclk);
    chk({stop_int, special_int}, 32'h3);
    $display("test special character done");
    wrap_up();
  end
endmodule

// ### test/ufc_peer.sv
`timescale 1ns/1ps
// far-side transmitter: takes flow characters, promptly or slowly
module ufc_peer (
  // clock
  input wire logic aclk,
  // flow character handshake
  input wire ufc_pkg::ufc_char_t flow_char,
  output logic flow_char_ready,
  // stall control and log of the last two characters taken
  input wire logic slow,
  output logic [15:0] got
);
  logic [1:0] wait_cnt = 2'h0;
  initial flow_char_ready = 1'h0;
  initial got = 16'h0000;
  always @(posedge aclk) begin
    if (flow_char.valid && flow_char_ready) begin
      got <= {got[7:0], flow_char.data};
    end
    wait_cnt <= flow_char.valid && !flow_char_ready ? wait_cnt + 2'h1 : 2'h0;
    flow_char_ready <= flow_char.valid && !flow_char_ready && (!slow || wait_cnt == 2'h3);
  end
endmodule
